/* hw/ccr_pkg.sv */
package ccr_pkg;
	// ======================================================
	// register offsets
	localparam logic [7:0] OFF_SP2_CTRL  = 8'h04;
	localparam logic [7:0] OFF_ADC_CLK   = 8'h06;
	localparam logic [7:0] OFF_DAC1_CLK  = 8'h07;
	localparam logic [7:0] OFF_DAC2_CLK  = 8'h08;
	localparam logic [7:0] OFF_ADC_CTRL  = 8'h0A;
	localparam logic [7:0] OFF_DAC1_CTRL = 8'h0B;
	// ======================================================
	// reset values
	localparam logic [7:0] RST_VALUE     = 8'h00;
	// ======================================================
	// writable bit masks, reserved bits read zero
	localparam logic [7:0] MASK_SP2      = 8'h9D;
	localparam logic [7:0] MASK_CLK      = 8'h53;
	localparam logic [7:0] MASK_ADC_CTRL = 8'h67;
	localparam logic [7:0] MASK_DAC1     = 8'hFF;
	// ======================================================
	// field positions
	localparam int BIT_ROLE    = 7;
	localparam int BIT_RATE    = 4;
	localparam int POS_DIV     = 2;
	localparam int BIT_SP2_SRC = 0;
	localparam int BIT_MCLK    = 6;
	localparam int BIT_PORT    = 4;
	localparam int POS_FMT     = 0;
	localparam int BIT_HOLD    = 6;
	localparam int BIT_ASOFT   = 5;
	localparam int POS_AIN     = 0;
	localparam int BIT_DEPH    = 7;
	localparam int BIT_SNGVOL  = 6;
	localparam int BIT_DSOFT   = 5;
	localparam int BIT_DZC     = 4;
	localparam int BIT_LOOP    = 3;
	localparam int BIT_INV     = 2;
	localparam int POS_MIX     = 0;
	// ======================================================
	// divider codes, counts in half master periods
	localparam logic [1:0] DIV_1   = 2'b00;
	localparam logic [1:0] DIV_1P5 = 2'b01;
	localparam logic [1:0] DIV_2   = 2'b10;
	localparam logic [1:0] DIV_3   = 2'b11;
	localparam logic [2:0] HALF_1   = 3'h2;
	localparam logic [2:0] HALF_1P5 = 3'h3;
	localparam logic [2:0] HALF_2   = 3'h4;
	localparam logic [2:0] HALF_3   = 3'h6;
	localparam logic [1:0] FMT_RSV0 = 2'b10;
endpackage

/* hw/ccr_mclk_div.sv */
`timescale 1ns/10ps
`default_nettype none
// ======================================================
// divides a master clock by 1, 1.5, 2 or 3 as a tick stream
module ccr_mclk_div
	import ccr_pkg::*;
(
	input  wire logic       sys_clk,
	input  wire logic       sys_rst,
	input  wire logic       mclk_rise,
	input  wire logic       mclk_fall,
	input  wire logic       enable,
	input  wire logic [1:0] div_code,
	output logic            tick
);
	logic [2:0] half_q;
	logic [2:0] limit;

	always_comb begin
		case (div_code)
			DIV_1:   limit = HALF_1;
			DIV_1P5: limit = HALF_1P5;
			DIV_2:   limit = HALF_2;
			default: limit = HALF_3;
		endcase
	end

	// counts both master edges so the 1.5 ratio needs no fraction
	always_ff @(posedge sys_clk) begin
		if (sys_rst || !enable) begin
			half_q <= 3'h0;
			tick   <= 1'b0;
		end else if (mclk_rise || mclk_fall) begin
			if (half_q + 3'h1 >= limit) begin
				half_q <= 3'h0;
				tick   <= 1'b1;
			end else begin
				half_q <= half_q + 3'h1;
				tick   <= 1'b0;
			end
		end else begin
			tick <= 1'b0;
		end
	end
endmodule
`default_nettype wire

/* hw/ccr_regs.sv */
`timescale 1ns/10ps
`default_nettype none
module ccr_regs
	import ccr_pkg::*;
(
	input  wire logic       sys_clk,
	input  wire logic       sys_rst,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	input  wire logic [7:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	output logic      [7:0] reg_rdata,
	input  wire logic       master_clock_pin_a,
	input  wire logic       master_clock_pin_b,
	input  wire logic       port_one_bit_clock,
	input  wire logic       port_one_frame_clock,
	input  wire logic       port_two_bit_clock_in,
	input  wire logic       port_two_frame_clock_in,
	output logic            port_two_bit_clock_out,
	output logic            port_two_frame_clock_out,
	output logic            port_two_clock_oe,
	output logic            port2_rate_mode,
	output logic            adc_mclk_sel,
	output logic            adc_bit_clock,
	output logic            adc_frame_clock,
	output logic      [1:0] adc_frame_format,
	output logic            adc_format_valid,
	output logic            dac1_master_clock_src_sel,
	output logic            dac1_bit_clock,
	output logic            dac1_frame_clock,
	output logic      [1:0] dac1_frame_format,
	output logic            dac2_master_clock_src_sel,
	output logic            dac2_bit_clock,
	output logic            dac2_frame_clock,
	output logic      [1:0] dac2_frame_format,
	output logic            adc_offset_hold,
	output logic            adc_gradual_level,
	output logic      [2:0] adc_input_pick,
	output logic            adc_input_valid,
	output logic            dac1_emphasis_undo,
	output logic            dac1_shared_volume,
	output logic            dac1_gradual_level,
	output logic            dac1_level_step,
	output logic            adc_level_step
);
	// ======================================================
	// register storage
	logic [7:0] sp2_q;
	logic [7:0] adc_clk_q;
	logic [7:0] dac1_clk_q;
	logic [7:0] dac2_clk_q;
	logic [7:0] adc_ctrl_q;
	logic [7:0] dac1_ctrl_q;

	// reserved bits masked so they read back zero
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			sp2_q       <= RST_VALUE;
			adc_clk_q   <= RST_VALUE;
			dac1_clk_q  <= RST_VALUE;
			dac2_clk_q  <= RST_VALUE;
			adc_ctrl_q  <= RST_VALUE;
			dac1_ctrl_q <= RST_VALUE;
		end else if (reg_wr) begin
			if (reg_addr == OFF_SP2_CTRL) begin
				sp2_q <= reg_wdata & MASK_SP2;
			end else if (reg_addr == OFF_ADC_CLK) begin
				adc_clk_q <= reg_wdata & MASK_CLK;
			end else if (reg_addr == OFF_DAC1_CLK) begin
				dac1_clk_q <= reg_wdata & MASK_CLK;
			end else if (reg_addr == OFF_DAC2_CLK) begin
				dac2_clk_q <= reg_wdata & MASK_CLK;
			end else if (reg_addr == OFF_ADC_CTRL) begin
				adc_ctrl_q <= reg_wdata & MASK_ADC_CTRL;
			end else if (reg_addr == OFF_DAC1_CTRL) begin
				dac1_ctrl_q <= reg_wdata & MASK_DAC1;
			end
		end
	end

	// ======================================================
	// read port, unmapped reads return zero
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			if (reg_addr == OFF_SP2_CTRL) begin
				reg_rdata <= sp2_q;
			end else if (reg_addr == OFF_ADC_CLK) begin
				reg_rdata <= adc_clk_q;
			end else if (reg_addr == OFF_DAC1_CLK) begin
				reg_rdata <= dac1_clk_q;
			end else if (reg_addr == OFF_DAC2_CLK) begin
				reg_rdata <= dac2_clk_q;
			end else if (reg_addr == OFF_ADC_CTRL) begin
				reg_rdata <= adc_ctrl_q;
			end else if (reg_addr == OFF_DAC1_CTRL) begin
				reg_rdata <= dac1_ctrl_q;
			end else begin
				reg_rdata <= 8'h00;
			end
		end
	end

	// ======================================================
	// pin synchronisers, first stage read only by second
	logic [5:0] pin_s1_q;
	logic [5:0] pin_s2_q;
	logic [5:0] pin_s3_q;
	logic [5:0] pin_raw;
	assign pin_raw = {master_clock_pin_b, master_clock_pin_a,
		port_two_frame_clock_in, port_two_bit_clock_in,
		port_one_frame_clock, port_one_bit_clock};

	genvar gi;
	generate
		for (gi = 0; gi < 6; gi++) begin : g_sync
			always_ff @(posedge sys_clk) begin
				if (sys_rst) begin
					pin_s1_q[gi] <= 1'b0;
					pin_s2_q[gi] <= 1'b0;
					pin_s3_q[gi] <= 1'b0;
				end else begin
					pin_s1_q[gi] <= pin_raw[gi];
					pin_s2_q[gi] <= pin_s1_q[gi];
					pin_s3_q[gi] <= pin_s2_q[gi];
				end
			end
		end
	endgenerate

	logic p1_bclk;
	logic p1_fclk;
	logic p2_bclk_pin;
	logic p2_fclk_pin;
	logic mca;
	logic mcb;
	assign p1_bclk     = pin_s2_q[0];
	assign p1_fclk     = pin_s2_q[1];
	assign p2_bclk_pin = pin_s2_q[2];
	assign p2_fclk_pin = pin_s2_q[3];
	assign mca         = pin_s2_q[4];
	assign mcb         = pin_s2_q[5];

	// ======================================================
	// port two master clock generation
	logic role_master;
	logic src_b;
	logic mc_rise;
	logic mc_fall;
	logic div_tick;
	logic [1:0] div_code;

	assign role_master = sp2_q[BIT_ROLE];
	assign src_b   = sp2_q[BIT_SP2_SRC];
	assign mc_rise = src_b ? (mcb & ~pin_s3_q[5]) : (mca & ~pin_s3_q[4]);
	assign mc_fall = src_b ? (~mcb & pin_s3_q[5]) : (~mca & pin_s3_q[4]);
	assign div_code = sp2_q[POS_DIV +: 2];

	// divider gated off in slave mode
	ccr_mclk_div u_div (
		.sys_clk   (sys_clk),
		.sys_rst   (sys_rst),
		.mclk_rise (mc_rise),
		.mclk_fall (mc_fall),
		.enable    (role_master),
		.div_code  (div_code),
		.tick      (div_tick)
	);

	// single rate 64 bit clocks per frame, double rate 32
	logic [6:0] bit_cnt_q;
	logic       rate_q;
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			rate_q <= 1'b0;
		end else if (role_master) begin
			rate_q <= sp2_q[BIT_RATE];
		end
	end

	// master clocks only run while port is master
	always_ff @(posedge sys_clk) begin
		if (sys_rst || !role_master) begin
			bit_cnt_q <= 7'h00;
		end else if (div_tick) begin
			bit_cnt_q <= bit_cnt_q + 7'h01;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			port_two_bit_clock_out   <= 1'b0;
			port_two_frame_clock_out <= 1'b0;
		end else begin
			port_two_bit_clock_out <= role_master & bit_cnt_q[0];
			port_two_frame_clock_out <= role_master &
				(rate_q ? bit_cnt_q[5] : bit_cnt_q[6]);
		end
	end
	assign port_two_clock_oe = role_master;
	assign port2_rate_mode   = rate_q;

	logic p2_bclk;
	logic p2_fclk;
	assign p2_bclk = role_master ? port_two_bit_clock_out : p2_bclk_pin;
	assign p2_fclk = role_master ? port_two_frame_clock_out : p2_fclk_pin;

	// ======================================================
	// converter clock routing
	// adc master clock pin
	assign adc_mclk_sel = adc_clk_q[BIT_MCLK];
	assign adc_bit_clock   = adc_clk_q[BIT_PORT] ? p2_bclk : p1_bclk;
	assign adc_frame_clock = adc_clk_q[BIT_PORT] ? p2_fclk : p1_fclk;
	assign adc_frame_format = adc_clk_q[POS_FMT +: 2];
	assign adc_format_valid = ~adc_clk_q[POS_FMT + 1];
	assign dac1_master_clock_src_sel = dac1_clk_q[BIT_MCLK];
	assign dac1_bit_clock   = dac1_clk_q[BIT_PORT] ? p2_bclk : p1_bclk;
	assign dac1_frame_clock = dac1_clk_q[BIT_PORT] ? p2_fclk : p1_fclk;
	assign dac1_frame_format = dac1_clk_q[POS_FMT +: 2];
	assign dac2_master_clock_src_sel = dac2_clk_q[BIT_MCLK];
	assign dac2_bit_clock   = dac2_clk_q[BIT_PORT] ? p2_bclk : p1_bclk;
	assign dac2_frame_clock = dac2_clk_q[BIT_PORT] ? p2_fclk : p1_fclk;
	assign dac2_frame_format = dac2_clk_q[POS_FMT +: 2];

	// ======================================================
	// processing controls
	// offset hold to the filter; host sets it first
	assign adc_offset_hold   = adc_ctrl_q[BIT_HOLD];
	assign adc_gradual_level = adc_ctrl_q[BIT_ASOFT];
	// input pick valid only for codes 1 to 5
	assign adc_input_pick  = adc_ctrl_q[POS_AIN +: 3];
	assign adc_input_valid = (adc_input_pick != 3'h0) &&
		(adc_input_pick <= 3'h5);
	assign dac1_emphasis_undo = dac1_ctrl_q[BIT_DEPH] & ~rate_q;
	assign dac1_shared_volume = dac1_ctrl_q[BIT_SNGVOL];
	assign dac1_gradual_level = dac1_ctrl_q[BIT_DSOFT];

	// ======================================================
	// ramp pacing: one 1/8 dB step per frame, 1 dB per 8 frames
	logic adc_f_q;
	logic dac1_f_q;
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			adc_f_q  <= 1'b0;
			dac1_f_q <= 1'b0;
		end else begin
			adc_f_q  <= adc_frame_clock;
			dac1_f_q <= dac1_frame_clock;
		end
	end

	// adc step per frame when gradual
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			adc_level_step <= 1'b0;
		end else begin
			adc_level_step <= adc_gradual_level &
				adc_frame_clock & ~adc_f_q;
		end
	end

	// dac1 step per frame when gradual
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			dac1_level_step <= 1'b0;
		end else begin
			dac1_level_step <= dac1_gradual_level &
				dac1_frame_clock & ~dac1_f_q;
		end
	end

	// ======================================================
	// checks
	// master drives, slave releases
	a_role_drive: assert property (@(posedge sys_clk) disable iff (sys_rst)
		port_two_clock_oe == sp2_q[BIT_ROLE])
		else $error("port two drive does not follow role");

	// slave mode keeps generated bit clock low
	a_slave_quiet: assert property (@(posedge sys_clk) disable iff (sys_rst)
		!role_master ##1 !role_master |-> !port_two_bit_clock_out)
		else $error("bit clock generated in slave mode");

	// de-emphasis never active in double rate
	a_deph_single: assert property (@(posedge sys_clk) disable iff (sys_rst)
		rate_q |-> !dac1_emphasis_undo)
		else $error("de-emphasis active in double rate");

	a_pick_valid: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(adc_input_pick == 3'h0 || adc_input_pick > 3'h5) |-> !adc_input_valid)
		else $error("reserved input pick flagged valid");

	a_adc_fmt: assert property (@(posedge sys_clk) disable iff (sys_rst)
		adc_frame_format[1] |-> !adc_format_valid)
		else $error("reserved adc format flagged valid");

	// adc frame clock follows chosen port one
	a_adc_route: assert property (@(posedge sys_clk) disable iff (sys_rst)
		!adc_clk_q[BIT_PORT] |-> adc_frame_clock == pin_s2_q[1])
		else $error("adc frame clock misrouted");

	a_adc_step: assert property (@(posedge sys_clk) disable iff (sys_rst)
		adc_level_step |-> $past(adc_gradual_level))
		else $error("adc step without gradual level");

	a_dac1_step: assert property (@(posedge sys_clk) disable iff (sys_rst)
		dac1_level_step |-> $past(dac1_gradual_level))
		else $error("dac1 step without gradual level");

	// rate output follows the bit one cycle later as master
	a_rate_hold: assert property (@(posedge sys_clk) disable iff (sys_rst)
		role_master |=> port2_rate_mode == $past(sp2_q[BIT_RATE]))
		else $error("rate mode not taken");
endmodule
`default_nettype wire

/* tb/ccr_proc_model.sv */
`timescale 1ns/10ps
`default_nettype none
// ======================================================
// audio processor side: master clocks and port clocks
module ccr_proc_model (
	input  wire logic sys_clk,
	output logic      mclk_a,
	output logic      mclk_b,
	output logic      bit_one,
	output logic      frame_one,
	output logic      bit_two,
	output logic      frame_two
);
	logic [8:0] cnt_q;
	initial cnt_q = 9'h000;
	// one counter locks all phases, so checks find quiet spots
	always @(posedge sys_clk) begin
		cnt_q <= (cnt_q == 9'h17F) ? 9'h000 : cnt_q + 9'h001;
	end
	assign mclk_a    = (cnt_q % 12) < 6;
	assign mclk_b    = (cnt_q % 24) < 12;
	assign bit_one   = (cnt_q % 8) < 4;
	assign frame_one = (cnt_q % 128) < 64;
	// port two is the inverse of port one, so a wrong route shows
	assign bit_two   = ~bit_one;
	assign frame_two = ~frame_one;
endmodule
`default_nettype wire

/* tb/tb.sv */
`timescale 1ns/10ps
`default_nettype none
module tb
	import ccr_pkg::*;
();
	logic       sys_clk, sys_rst, reg_wr, reg_rd;
	logic [7:0] reg_addr, reg_wdata, reg_rdata;
	logic       master_clock_pin_a, master_clock_pin_b;
	logic       port_one_bit_clock, port_one_frame_clock;
	logic       pm_bit_two, pm_frame_two;
	logic       port_two_bit_clock_in, port_two_frame_clock_in;
	logic       port_two_bit_clock_out, port_two_frame_clock_out;
	logic       port_two_clock_oe, port2_rate_mode;
	logic       adc_mclk_sel, adc_bit_clock, adc_frame_clock;
	logic       adc_format_valid, dac1_master_clock_src_sel, dac1_bit_clock;
	logic       dac1_frame_clock, dac2_master_clock_src_sel, dac2_bit_clock;
	logic       dac2_frame_clock, adc_offset_hold, adc_gradual_level;
	logic       adc_input_valid, dac1_emphasis_undo, dac1_shared_volume;
	logic       dac1_gradual_level, dac1_level_step, adc_level_step;
	logic [1:0] adc_frame_format, dac1_frame_format, dac2_frame_format;
	logic [2:0] adc_input_pick;
	int         error_cnt, compares;
	logic [7:0] offs [6] = '{OFF_SP2_CTRL, OFF_ADC_CLK, OFF_DAC1_CLK,
		OFF_DAC2_CLK, OFF_ADC_CTRL, OFF_DAC1_CTRL};
	logic [7:0] masks [6] = '{MASK_SP2, MASK_CLK, MASK_CLK, MASK_CLK,
		MASK_ADC_CTRL, MASK_DAC1};
	int         halves [4] = '{2, 3, 4, 6};
	// ======================================================
	// port two wire: device drives only while master
	assign port_two_bit_clock_in   = port_two_clock_oe ?
		port_two_bit_clock_out : pm_bit_two;
	assign port_two_frame_clock_in = port_two_clock_oe ?
		port_two_frame_clock_out : pm_frame_two;
	ccr_regs dut (
		.sys_clk, .sys_rst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
		.reg_rdata, .master_clock_pin_a, .master_clock_pin_b,
		.port_one_bit_clock, .port_one_frame_clock, .port_two_bit_clock_in,
		.port_two_frame_clock_in, .port_two_bit_clock_out,
		.port_two_frame_clock_out, .port_two_clock_oe, .port2_rate_mode,
		.adc_mclk_sel, .adc_bit_clock, .adc_frame_clock, .adc_frame_format,
		.adc_format_valid, .dac1_master_clock_src_sel, .dac1_bit_clock,
		.dac1_frame_clock, .dac1_frame_format, .dac2_master_clock_src_sel,
		.dac2_bit_clock, .dac2_frame_clock, .dac2_frame_format,
		.adc_offset_hold, .adc_gradual_level, .adc_input_pick,
		.adc_input_valid, .dac1_emphasis_undo, .dac1_shared_volume,
		.dac1_gradual_level, .dac1_level_step, .adc_level_step
	);
	ccr_proc_model pm (
		.sys_clk, .mclk_a(master_clock_pin_a), .mclk_b(master_clock_pin_b),
		.bit_one(port_one_bit_clock), .frame_one(port_one_frame_clock),
		.bit_two(pm_bit_two), .frame_two(pm_frame_two)
	);
	initial sys_clk = 1'b0;
	always #12.5 sys_clk = ~sys_clk;
	// ======================================================
	// access tasks
	task automatic check(input string nm, input logic [7:0] seen,
		input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			error_cnt++;
			$display("unexpected %s: expected %h, seen %h", nm, exp, seen);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
		repeat (2) @(posedge sys_clk);
	endtask
	task automatic chk_rd(input logic [7:0] a, input logic [7:0] exp);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		// data stands until the next read, so late sampling is safe
		repeat (2) @(posedge sys_clk);
		check($sformatf("reg %h", a), reg_rdata, exp);
	endtask
	task automatic route(input logic sel);
		logic exp;
		wr(OFF_ADC_CLK, sel ? 8'h10 : 8'h40);
		wr(OFF_DAC1_CLK, sel ? 8'h10 : 8'h40);
		wr(OFF_DAC2_CLK, sel ? 8'h10 : 8'h40);
		check("adc mclk", adc_mclk_sel, !sel);
		check("dac1_master_clock_src", dac1_master_clock_src_sel, !sel);
		check("dac2_master_clock_src", dac2_master_clock_src_sel, !sel);
		@(posedge port_one_frame_clock);
		repeat (6) @(posedge sys_clk);
		exp = !sel;
		check("adc frame", adc_frame_clock, exp);
		check("dac1 frame", dac1_frame_clock, exp);
		check("dac2 frame", dac2_frame_clock, exp);
		check("adc bit", adc_bit_clock, exp);
		check("dac1 bit", dac1_bit_clock, exp);
		check("dac2 bit", dac2_bit_clock, exp);
	endtask
	task automatic steps(input logic [7:0] d, input logic [7:0] n);
		int a, b;
		wr(OFF_ADC_CTRL, d);
		wr(OFF_DAC1_CTRL, d);
		check("adc soft", adc_gradual_level, 8'(d[BIT_ASOFT]));
		check("dac1_gradual_level", dac1_gradual_level, 8'(d[BIT_DSOFT]));
		a = 0;
		b = 0;
		@(posedge port_one_frame_clock);
		repeat (10) @(posedge sys_clk);
		repeat (1024) begin
			@(posedge sys_clk);
			a += adc_level_step;
			b += dac1_level_step;
		end
		check("adc steps", a[7:0], n);
		check("dac1 steps", b[7:0], n);
	endtask
	task automatic divchk(input int code, input int src);
		int n, exp;
		logic prev;
		wr(OFF_SP2_CTRL, 8'h80 | 8'(code << 2) | 8'(src));
		repeat (24) @(posedge sys_clk);
		n = 0;
		prev = port_two_bit_clock_out;
		repeat (288) begin
			@(posedge sys_clk);
			if (port_two_bit_clock_out !== prev) n++;
			prev = port_two_bit_clock_out;
		end
		exp = (src ? 24 : 48) / halves[code];
		check("bit clock toggles", 8'(n >= exp - 1 && n <= exp + 1), 8'h01);
	endtask
	task automatic framechk(input logic [7:0] d, input int exp);
		int n;
		logic pf, pb;
		wr(OFF_SP2_CTRL, d);
		// a rate switch may cut one frame half short, so skip two
		repeat (2) begin
			pf = port_two_frame_clock_out;
			while (port_two_frame_clock_out === pf) @(posedge sys_clk);
		end
		n = 0;
		pf = port_two_frame_clock_out;
		pb = port_two_bit_clock_out;
		while (port_two_frame_clock_out === pf) begin
			@(posedge sys_clk);
			if (port_two_bit_clock_out !== pb) n++;
			pb = port_two_bit_clock_out;
		end
		check("bit edges per frame half", 8'(n), 8'(exp));
	endtask
	task automatic end_of_test;
		$display("compares %0d error_cnt %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// ======================================================
	// tests
	initial begin
		sys_rst = 1'b1;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		error_cnt = 0;
		compares = 0;
		repeat (5) @(posedge sys_clk);
		sys_rst <= 1'b0;
		@(posedge sys_clk);
		foreach (offs[i]) chk_rd(offs[i], RST_VALUE);
		foreach (offs[i]) begin
			wr(offs[i], 8'hFF);
			chk_rd(offs[i], masks[i]);
		end
		wr(8'h05, 8'hFF);
		chk_rd(8'h05, 8'h00);
		chk_rd(OFF_SP2_CTRL, MASK_SP2);
		check("oe", port_two_clock_oe, 8'h01);
		check("hold", adc_offset_hold, 8'h01);
		check("shared", dac1_shared_volume, 8'h01);
		wr(OFF_SP2_CTRL, 8'h00);
		check("oe", port_two_clock_oe, 8'h00);
		check("rate", port2_rate_mode, 8'h01);
		wr(OFF_SP2_CTRL, 8'h80);
		check("rate", port2_rate_mode, 8'h00);
		check("deemph", dac1_emphasis_undo, 8'h01);
		wr(OFF_SP2_CTRL, 8'h90);
		check("rate", port2_rate_mode, 8'h01);
		check("deemph", dac1_emphasis_undo, 8'h00);
		wr(OFF_SP2_CTRL, 8'h00);
		check("rate", port2_rate_mode, 8'h01);
		for (int c = 0; c < 4; c++) begin
			wr(OFF_ADC_CLK, 8'(c));
			wr(OFF_DAC1_CLK, 8'(c));
			wr(OFF_DAC2_CLK, 8'(c));
			check("adc fmt", adc_frame_format, 8'(c));
			check("adc fmt ok", adc_format_valid, 8'(c < 2));
			check("dac1 fmt", dac1_frame_format, 8'(c));
			check("dac2 fmt", dac2_frame_format, 8'(c));
		end
		for (int p = 0; p < 8; p++) begin
			wr(OFF_ADC_CTRL, 8'(p));
			check("pick", adc_input_pick, 8'(p));
			check("pick ok", adc_input_valid, 8'(p >= 1 && p <= 5));
		end
		check("no hold", adc_offset_hold, 8'h00);
		wr(OFF_ADC_CTRL, 8'h41);
		check("hold set", adc_offset_hold, 8'h01);
		route(1'b1);
		route(1'b0);
		steps(8'h20, 8'h08);
		steps(8'h00, 8'h00);
		for (int k = 0; k < 8; k++) divchk(k % 4, k / 4);
		framechk(8'h90, 32);
		framechk(8'h80, 64);
		wr(OFF_SP2_CTRL, 8'h0D);
		divchk_slave();
		end_of_test();
	end
	task automatic divchk_slave;
		int n;
		n = 0;
		repeat (288) begin
			@(posedge sys_clk);
			if (port_two_bit_clock_out !== 1'b0) n++;
		end
		check("slave bit clock", 8'(n), 8'h00);
		check("oe", port_two_clock_oe, 8'h00);
	endtask
	initial begin
		#1000000;
		error_cnt++;
		end_of_test();
	end
endmodule
`default_nettype wire
